// ### pbr_pkg.sv
// Purpose: Shared constants and types for the power-down, rotate and bit-clear execute unit
// Assumes: 10-bit instruction words, 4-bit data nibbles
// Notes: Opcodes are full 10-bit words except the bit-clear group, matched on its top 8 bits
package pbr_pkg;
    localparam int INSTR_W = 10;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 8;
    localparam logic [9:0] OPC_CLOCK_RUN_PD = 10'h002;
    localparam logic [9:0] OPC_RAM_BACKUP_PD = 10'h008;
    localparam logic [9:0] OPC_PD_ENABLE = 10'h010;
    localparam logic [9:0] OPC_ROTATE_RIGHT = 10'h01D;
    localparam logic [7:0] OPC_BIT_CLEAR_HI = 8'h13;
    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic [1:0] POWER_RUN = 2'h0;

    // Core power state, one-hot
    typedef enum logic [2:0] {
        PBR_RUN = 3'b001,
        PBR_CLOCK_RUN = 3'b010,
        PBR_RAM_BACKUP = 3'b100
    } pbr_power_t;

    // Memory write request toward the data RAM
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [3:0] data;
    } pbr_mem_wr_t;

    // Whole state of the unit
    typedef struct packed {
        pbr_power_t power;
        logic pd_armed;
        logic [3:0] acc;
        logic carry_flag;
        pbr_mem_wr_t wr;
        logic done;
    } pbr_state_t;
endpackage

// ### pbr_exec.sv
// Purpose: Executes the power-down, rotate-right-through-carry and memory bit-clear instructions
// Assumes: One instruction per cycle when i_valid is high; memory read data is combinational
// Assumes: The write-back load and a rotate are not issued in the same cycle
// Notes: Leaving a power-down state takes i_wake (an interrupt or reset in the real core)
// Notes: A write-back load wins over a rotate that shares its cycle
// Notes on behaviour
// - Clock-run power-down takes effect only straight after enable; else no-op
// - RAM back-up op straight after enable enters back-up state, RAM kept
// - RAM back-up op without preceding enable is a no-op
// - Rotate right: old carry into bit 3, bit 0 into carry
// - Bit clear writes zero to bit j of nibble at data pointer
`timescale 1ns/1ps
`default_nettype none
module pbr_exec (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire logic [pbr_pkg::INSTR_W-1:0] i_instr,
    input wire logic [pbr_pkg::ADDR_W-1:0] i_data_pointer,
    input wire logic [pbr_pkg::NIB_W-1:0] i_mem_rdata,
    input wire logic i_wake,
    input wire logic i_acc_load,
    input wire logic [pbr_pkg::NIB_W-1:0] i_acc_wdata,
    input wire logic i_carry_wdata,
    output logic [pbr_pkg::NIB_W-1:0] o_acc,
    output logic o_carry_flag,
    output logic o_mem_we,
    output logic [pbr_pkg::ADDR_W-1:0] o_mem_addr,
    output logic [pbr_pkg::NIB_W-1:0] o_mem_wdata,
    output logic o_clock_run,
    output logic o_ram_backup,
    output logic o_done,
    output logic o_skip
);
    import pbr_pkg::*;

    // Decode helpers; all remembered state lives in the one struct
    pbr_state_t state;
    pbr_state_t next_state;
    logic running;
    logic is_bit_clear;
    logic [1:0] bit_sel;

    // Fetch is accepted only in the run state
    assign running = (state.power == PBR_RUN);
    assign is_bit_clear = (i_instr[9:2] == OPC_BIT_CLEAR_HI);
    assign bit_sel = i_instr[1:0];

    // Decode and execute; the enable is armed only for the very next instruction.
    // Idle cycles leave the arming alone, so a stalled fetch cannot lose it.
    always_comb begin
        next_state = state;
        next_state.wr.we = 1'b0;
        next_state.done = 1'b0;
        case (state.power)
            PBR_CLOCK_RUN, PBR_RAM_BACKUP: begin
                // Core halted: fetch and write-back are ignored, only wake counts
                if (i_wake) begin
                    next_state.power = PBR_RUN;
                end
            end
            PBR_RUN: begin
                if (i_valid) begin
                    next_state.done = 1'b1;
                    next_state.pd_armed = (i_instr == OPC_PD_ENABLE);
                    if (i_instr == OPC_CLOCK_RUN_PD) begin
                        // Unarmed request falls through as a no-operation
                        if (state.pd_armed) begin
                            next_state.power = PBR_CLOCK_RUN;
                        end
                    end else if (i_instr == OPC_RAM_BACKUP_PD) begin
                        // Unarmed request falls through as a no-operation
                        if (state.pd_armed) begin
                            next_state.power = PBR_RAM_BACKUP;
                        end
                    end else if (i_instr == OPC_ROTATE_RIGHT) begin
                        next_state.acc = {state.carry_flag, state.acc[3:1]};
                        next_state.carry_flag = state.acc[0];
                    end else if (is_bit_clear) begin
                        // Read-modify-write so the other three bits survive
                        next_state.wr.we = 1'b1;
                        next_state.wr.addr = i_data_pointer;
                        next_state.wr.data = i_mem_rdata & ~(4'h1 << bit_sel);
                    end
                end
                // Write-back from the rest of the core; it wins over a rotate in the
                // same cycle, which the core never issues together with a load
                if (i_acc_load) begin
                    next_state.acc = i_acc_wdata;
                    next_state.carry_flag = i_carry_wdata;
                end
            end
            default: begin
                // Corrupted power code: recover to run with nothing armed
                next_state.power = PBR_RUN;
                next_state.pd_armed = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= '{power: PBR_RUN, pd_armed: 1'b0, acc: ACC_RESET, carry_flag: 1'b0,
                       wr: '{we: 1'b0, addr: 8'h00, data: 4'h0},
                       done: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // Outputs from flops, except o_clock_run and o_ram_backup, which compare the power flops, and the constant o_skip
    // Skip is tied low: none of these ops skips the following word
    assign o_acc = state.acc;
    assign o_carry_flag = state.carry_flag;
    assign o_mem_we = state.wr.we;
    assign o_mem_addr = state.wr.addr;
    assign o_mem_wdata = state.wr.data;
    assign o_clock_run = (state.power == PBR_CLOCK_RUN);
    assign o_ram_backup = (state.power == PBR_RAM_BACKUP);
    assign o_done = state.done;
    assign o_skip = 1'b0;

    // Clock-run entry looks only at the arming left behind by the slot before
    a_clock_run_entry: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && i_instr == OPC_CLOCK_RUN_PD
        |=> o_clock_run == $past(state.pd_armed))
        else $error("clock-run entry wrong");
    a_clock_run_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_clock_run) |-> $past(i_instr) == OPC_CLOCK_RUN_PD && $past(state.pd_armed, 1))
        else $error("clock-run entered without enable");
    a_unarmed_clock_noop: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && i_instr == OPC_CLOCK_RUN_PD && !state.pd_armed && !i_acc_load
        |=> !o_clock_run && !o_ram_backup && $stable(o_acc) && !o_mem_we)
        else $error("unarmed clock-run not a no-op");

    // Back-up entry and its no-operation twin; RAM is left alone while backed up
    a_backup_entry: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && i_instr == OPC_RAM_BACKUP_PD && state.pd_armed
        |=> o_ram_backup && !o_clock_run)
        else $error("backup not entered");
    a_backup_noop: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && i_instr == OPC_RAM_BACKUP_PD && !state.pd_armed && !i_acc_load
        |=> !o_ram_backup && $stable(o_acc) && $stable(o_carry_flag) && !o_mem_we)
        else $error("unarmed backup not a no-op");
    a_backup_no_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_ram_backup |-> !o_mem_we)
        else $error("memory written in backup state");

    // Arming window: set by the enable, cleared by any other op, kept over idle slots
    a_arm_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && i_instr == OPC_PD_ENABLE |=> state.pd_armed)
        else $error("enable did not arm");
    a_arm_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && i_instr != OPC_PD_ENABLE |=> !state.pd_armed)
        else $error("arming outlived the next op");
    a_arm_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && !i_valid |=> $stable(state.pd_armed))
        else $error("idle slot changed arming");

    // One power state at a time, and only wake leaves it
    a_power_exclusive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(o_clock_run && o_ram_backup))
        else $error("two power states at once");
    a_wake_return: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !running && i_wake |=> !o_clock_run && !o_ram_backup)
        else $error("wake did not return to run");
    a_power_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !running && !i_wake |=> $stable(o_clock_run) && $stable(o_ram_backup))
        else $error("power state left without wake");

    // Refused slots leave no trace; idle slots neither complete nor write memory
    a_refused_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !running |=> !o_done && !o_mem_we && $stable(o_acc) && $stable(o_carry_flag))
        else $error("halted core executed something");
    a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && !i_valid |=> !o_done && !o_mem_we)
        else $error("idle slot executed something");

    // Rotate through carry, and the write-back that presets it
    a_rotate_value: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && i_instr == OPC_ROTATE_RIGHT && !i_acc_load
        |=> o_acc == {$past(o_carry_flag), $past(o_acc[3:1])}
        && o_carry_flag == $past(o_acc[0]))
        else $error("rotate result wrong");
    a_load_value: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_acc_load
        |=> o_acc == $past(i_acc_wdata) && o_carry_flag == $past(i_carry_wdata))
        else $error("write-back load wrong");
    a_carry_only_rotate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(running && (i_acc_load || (i_valid && i_instr == OPC_ROTATE_RIGHT)))
        |=> $stable(o_carry_flag))
        else $error("carry changed by other op");

    // Bit clear writes one nibble and the write port then holds still
    a_bit_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid && is_bit_clear |=> o_mem_we && o_mem_addr == $past(i_data_pointer)
        && o_mem_wdata[$past(bit_sel)] == 1'b0
        && (o_mem_wdata | (4'h1 << $past(bit_sel)))
        == ($past(i_mem_rdata) | (4'h1 << $past(bit_sel))))
        else $error("bit clear wrong");
    a_write_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(running && i_valid && is_bit_clear) |=> $stable(o_mem_addr) && $stable(o_mem_wdata))
        else $error("write port moved without bit clear");
    a_write_source: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_mem_we |-> $past(running) && $past(i_valid) && $past(is_bit_clear))
        else $error("memory write without bit clear");

    // Every accepted op completes in the next cycle, and only accepted ops do
    a_one_cycle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        running && i_valid |=> o_done && !o_skip)
        else $error("op did not finish in one cycle");
    a_done_source: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_done |-> $past(running) && $past(i_valid))
        else $error("done without an accepted op");

    // Main scenarios the stimulus must reach
    c_clock_run: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_clock_run));
    c_backup: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_ram_backup));
    c_rotate_carry: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_carry_flag));
    c_bit_clear: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_mem_we);
    c_refused: cover property (@(posedge i_clk) disable iff (!i_reset_n) !running && i_valid);
endmodule
`default_nettype wire

// ### test_power_down_rotate_bitclear_ops.sv
// Purpose: Self-checking bench for the power-down, rotate and bit-clear unit
// Assumes: Results show one cycle after an accepted instruction
// Notes: Acc and carry are preset through the write-back load before rotates
`timescale 1ns/1ps
`default_nettype none
module test_power_down_rotate_bitclear_ops;
    import pbr_pkg::*;
    logic i_clk, i_reset_n, i_valid, i_wake, i_acc_load, i_carry_wdata;
    logic [9:0] i_instr;
    logic [7:0] i_data_pointer, o_mem_addr, ptr;
    logic [3:0] i_mem_rdata, i_acc_wdata, o_acc, o_mem_wdata, rd;
    logic o_carry_flag, o_mem_we, o_clock_run, o_ram_backup, o_done, o_skip;
    logic [31:0] seed = 32'hC44B;
    logic [4:0] model;
    logic [1:0] j;
    int n_errors = 0;
    int checks_done = 0;
    pbr_exec u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_valid(i_valid),
        .i_instr(i_instr), .i_data_pointer(i_data_pointer), .i_mem_rdata(i_mem_rdata),
        .i_wake(i_wake), .i_acc_load(i_acc_load), .i_acc_wdata(i_acc_wdata),
        .i_carry_wdata(i_carry_wdata), .o_acc(o_acc), .o_carry_flag(o_carry_flag),
        .o_mem_we(o_mem_we),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_clock_run(o_clock_run),
        .o_ram_backup(o_ram_backup), .o_done(o_done), .o_skip(o_skip));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Model is {carry, acc}: old carry to bit 3, bit 0 to carry
    function automatic logic [4:0] rot(input logic [4:0] m);
        return {m[0], m[4], m[3:1]};
    endfunction
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One slot, then an idle cycle; idle cycles must not drop the arming
    task automatic op(input logic [9:0] x, input logic [2:0] st);
        logic bc;
        @(posedge i_clk);
        seed = lfsr(seed);
        ptr = seed[7:0];
        rd = seed[11:8];
        i_valid <= 1'b1;
        i_instr <= x;
        i_data_pointer <= ptr;
        i_mem_rdata <= rd;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        if (x === OPC_ROTATE_RIGHT && st[2]) model = rot(model);
        bc = st[2] && x[9:2] === OPC_BIT_CLEAR_HI;
        chk({o_done, o_clock_run, o_ram_backup, o_mem_we}, {st, bc});
        chk({o_skip, o_carry_flag, o_acc}, {1'b0, model});
    endtask
    // Write-back load gives the rotate checks non-zero data to work on
    task automatic load(input logic [4:0] d);
        @(posedge i_clk);
        i_acc_load <= 1'b1;
        i_carry_wdata <= d[4];
        i_acc_wdata <= d[3:0];
        @(posedge i_clk);
        i_acc_load <= 1'b0;
        #1;
        model = d;
        chk({o_carry_flag, o_acc}, d);
    endtask
    task automatic wake;
        @(posedge i_clk);
        i_wake <= 1'b1;
        @(posedge i_clk);
        i_wake <= 1'b0;
        #1;
        chk({o_clock_run, o_ram_backup}, 2'h0);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        {i_reset_n, i_valid, i_wake, i_instr, i_data_pointer, i_mem_rdata} = '0;
        {i_acc_load, i_acc_wdata, i_carry_wdata} = '0;
        model = '0;
        repeat (3) @(posedge i_clk);
        chk({o_done, o_mem_we, o_clock_run, o_ram_backup, o_acc}, 8'h00);
        i_reset_n <= 1'b1;
        load(5'h1E);
        op(OPC_CLOCK_RUN_PD, 3'h4);
        op(OPC_RAM_BACKUP_PD, 3'h4);
        op(OPC_PD_ENABLE, 3'h4);
        op(OPC_ROTATE_RIGHT, 3'h4);
        op(OPC_RAM_BACKUP_PD, 3'h4);
        op(OPC_PD_ENABLE, 3'h4);
        op(OPC_CLOCK_RUN_PD, 3'h6);
        op(OPC_ROTATE_RIGHT, 3'h2);
        wake;
        op(OPC_PD_ENABLE, 3'h4);
        op(OPC_RAM_BACKUP_PD, 3'h5);
        op(OPC_PD_ENABLE, 3'h1);
        wake;
        op(OPC_CLOCK_RUN_PD, 3'h4);
        load(5'h01);
        op(OPC_ROTATE_RIGHT, 3'h4);
        // Random mix of rotates and bit clears over all four bit positions
        repeat (40) begin
            seed = lfsr(seed);
            j = seed[2:1];
            if (seed[0]) begin
                if (seed[3]) begin
                    load(seed[8:4]);
                end
                op(OPC_ROTATE_RIGHT, 3'h4);
            end else begin
                op({OPC_BIT_CLEAR_HI, j}, 3'h4);
                chk({o_mem_we, o_mem_addr, o_mem_wdata}, {1'b1, ptr, rd & ~(4'h1 << j)});
            end
        end
        end_sim;
    end
endmodule
`default_nettype wire
